/* File: rtl/thr_regs.vh */
`ifndef THR_REGS_VH
`define THR_REGS_VH

// Clock and millisecond timebase.
`define THR_CLK_HZ        40000000
`define THR_MS_CYCLES     (`THR_CLK_HZ / 1000)

// Toner supply timing, in milliseconds.
`define THR_T_SETTLE_MS   16'd1000
`define THR_T_WAIT_MS     16'd1000
`define THR_T_PUMP_MS     16'd2000
`define THR_T_STALL_MS    16'd2000
`define THR_T_CLUTCH_MS   16'd500
`define THR_T_AGIT_MS     16'd500

// Register byte addresses.
`define THR_A_CTRL        8'h00
`define THR_A_STATUS      8'h04
`define THR_A_MASK        8'h08
`define THR_A_ON_CNT      8'h0c
`define THR_A_OFF_CNT     8'h10
`define THR_A_ROT_WIN     8'h14
`define THR_A_LIVE        8'h18
`define THR_A_COPY_CNT    8'h1c
`define THR_A_ONTIME0     8'h20
`define THR_A_ONTIME4     8'h30

// Reset values.
`define THR_RST_CTRL      1'b1
`define THR_RST_ON_CNT    32'd25000
`define THR_RST_OFF_CNT   32'd25000
`define THR_RST_ROT_WIN   16'd3000
`define THR_RST_PINS      12'h300

// Status and mask bit positions.
`define THR_ST_STALL      0
`define THR_ST_NEAR_FULL  1
`define THR_ST_FULL       2
`define THR_ST_NOT_SET    3
`define THR_ST_COVER_OPEN 4
`define THR_ST_PURGE      5
`define THR_ST_W          6

// Synchronised pin vector positions.
`define THR_P_HOP_LOW     0
`define THR_P_CLUTCH      1
`define THR_P_BANK        2
`define THR_P_BOT_AGIT    3
`define THR_P_CYL_AGIT    4
`define THR_P_DRUM        5
`define THR_P_AGIT_ROT    6
`define THR_P_OVF_ROT     7
`define THR_P_BOT_SET     8
`define THR_P_COVER       9
`define THR_P_COPY        10
`define THR_P_PATH_EMPTY  11
`define THR_P_W           12

`endif

/* File: rtl/thr_rot_watch.v */
`timescale 1ns/10ps
`default_nettype none

// Reports a rotation sensor as stuck when its output holds still for a whole
// window of milliseconds while its drive runs. A stopped drive freezes the
// count, so an idle machine never looks like a jammed agitator.
module thr_rot_watch (
  input  wire        clk,
  input  wire        rstn,
  input  wire        ms_tick,
  input  wire        drive_on,
  input  wire        sense,
  input  wire [15:0] window_ms,
  output reg         stuck_reg
);

  reg        sense_prev_reg;
  reg [15:0] still_ms_reg;
  wire       edge_seen = sense ^ sense_prev_reg;

  always @(posedge clk) begin
    if (!rstn) begin
      sense_prev_reg <= 1'b0;
      still_ms_reg   <= 16'h0000;
      stuck_reg      <= 1'b0;
    end else begin
      sense_prev_reg <= sense;
      if (edge_seen) begin
        still_ms_reg <= 16'h0000;
        stuck_reg    <= 1'b0;
      end else if (ms_tick && drive_on) begin
        if (still_ms_reg >= window_ms) begin
          stuck_reg <= 1'b1; // RL15
        end else begin
          still_ms_reg <= still_ms_reg + 16'h0001;
        end
      end
    end
  end

endmodule // thr_rot_watch

`default_nettype wire

/* File: rtl/thr_hopper_ctrl.v */
// What this block does
// RL1: The hopper level is sampled 1 s after the hopper agitator stops and 1 s after the pump stops.
// RL2: A sample showing too little toner leads to a 1 s wait and then 2 s of pump running.
// RL3: Too little toner reported for longer than 2 s raises the supply stall fault.
// RL4: The hopper agitator runs whenever the pump runs.
// RL5: Each 500 ms of supply clutch on-time runs the hopper agitator for 500 ms.
// RL6: The clutch on-time count clears when the agitator starts and at once when toner is present.
// RL7: On-time totals are kept for bank motor, supply clutch, bottle agitator, cylinder agitator and pump.
// RL8: The recycle shutter is held on while recycling and dropped once copies exceed the on count.
// RL9: After the shutter drops, recycling stays off for the purge count of copies.
// RL10: Both the recycle interval and purge duration counts are software settable, 25000 by default.
// RL11: A bottle agitator rotation sensor that stops changing flags the bottle as nearly full.
// RL12: An overflow sensor that stops changing flags toner full, feeds out the paper path, then stops.
// RL13: A bottle set sensor reporting a bad install raises the bottle not set error.
// RL14: All operation is inhibited while the bottle cover switch does not report it attached; the code stops only the refill sequencer, pump and hopper agitator.
// RL15: A rotation sensor is stuck when no transition comes within a set window while its drive runs.
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "thr_regs.vh"

module thr_hopper_ctrl #(
  parameter MS_CYCLES = `THR_MS_CYCLES
) (
  input  wire                  clk,
  input  wire                  rstn,
  input  wire [7:0]            addr,
  input  wire [31:0]           wdata,
  input  wire                  wr,
  input  wire                  rd,
  output reg  [31:0]           rdata,
  output wire                  irq,
  input  wire [`THR_P_W-1:0]   pins,
  output reg                   pump_motor,
  output reg                   hopper_agitator,
  output reg                   shutter_solenoid,
  output reg                   machine_inhibit,
  output reg                   bottle_near_full,
  output reg                   toner_full,
  output reg                   bottle_not_set,
  output reg                   feed_out_request,
  output reg                   stop_printing,
  output wire                  hopper_supply_stall_fault
);

  localparam [3:0] S_IDLE   = 4'b0001;
  localparam [3:0] S_SETTLE = 4'b0010;
  localparam [3:0] S_WAIT   = 4'b0100;
  localparam [3:0] S_PUMP   = 4'b1000;

  // Two flops per pin, reset to the idle levels so that no false event follows reset.
  reg [`THR_P_W-1:0] pin_meta_reg;
  reg [`THR_P_W-1:0] pin_reg;
  always @(posedge clk) begin
    if (!rstn) begin
      pin_meta_reg <= `THR_RST_PINS;
      pin_reg      <= `THR_RST_PINS;
    end else begin
      pin_meta_reg <= pins;
      pin_reg      <= pin_meta_reg;
    end
  end

  wire hop_low    = pin_reg[`THR_P_HOP_LOW];
  wire cover_ok   = pin_reg[`THR_P_COVER];
  wire path_empty = pin_reg[`THR_P_PATH_EMPTY];

  // Millisecond timebase.
  reg [15:0] div_reg;
  wire       ms_tick = (div_reg == MS_CYCLES - 1);
  always @(posedge clk) begin
    if (!rstn || ms_tick)
      div_reg <= 16'h0000;
    else
      div_reg <= div_reg + 16'h0001;
  end

  // Software registers.
  reg                   ctrl_en_reg;
  reg [`THR_ST_W-1:0]   status_reg;
  reg [`THR_ST_W-1:0]   mask_reg;
  reg [31:0]            on_cnt_reg;
  reg [31:0]            off_cnt_reg;
  reg [15:0]            rot_win_reg;
  reg [31:0]            ontime_reg [0:4];
  wire                  run = ctrl_en_reg && cover_ok;

  // Hopper refill sequencer state.
  reg [3:0]  hop_state_reg;
  reg [15:0] hop_ms_reg;
  reg        agit_run_reg;
  reg [15:0] agit_ms_reg;
  reg [15:0] clutch_ms_reg;
  reg        stall_armed_reg;
  reg [15:0] stall_ms_reg;
  reg        stall_evt;
  reg        pump_prev_reg;
  reg        agit_prev_reg;
  wire       pump_fall = pump_prev_reg && !pump_motor;
  wire       agit_fall = agit_prev_reg && !hopper_agitator;
  wire       agit_rise = !agit_prev_reg && hopper_agitator;

  always @(posedge clk) begin
    if (!rstn) begin
      hop_state_reg   <= S_SETTLE;
      hop_ms_reg      <= 16'h0000;
      pump_motor      <= 1'b0;
      stall_armed_reg <= 1'b0;
      stall_ms_reg    <= 16'h0000;
      stall_evt       <= 1'b0;
    end else if (!run) begin
      // Inhibited: stop the pump and resample once operation resumes.
      hop_state_reg   <= S_SETTLE; // RL14
      hop_ms_reg      <= 16'h0000;
      pump_motor      <= 1'b0;
      stall_armed_reg <= 1'b0;
      stall_evt       <= 1'b0;
    end else begin
      stall_evt <= 1'b0;
      case (hop_state_reg)
        S_IDLE: begin
          pump_motor <= 1'b0;
          if (agit_fall || pump_fall) begin
            hop_state_reg <= S_SETTLE;
            hop_ms_reg    <= 16'h0000;
          end
        end
        S_SETTLE: begin
          pump_motor <= 1'b0;
          if (agit_fall || pump_fall) begin
            hop_ms_reg <= 16'h0000;
          end else if (ms_tick) begin
            if (hop_ms_reg == `THR_T_SETTLE_MS - 16'd1) begin
              hop_ms_reg    <= 16'h0000;
              hop_state_reg <= hop_low ? S_WAIT : S_IDLE; // RL1
            end else begin
              hop_ms_reg <= hop_ms_reg + 16'h0001;
            end
          end
        end
        S_WAIT: begin
          if (ms_tick) begin
            if (hop_ms_reg == `THR_T_WAIT_MS - 16'd1) begin
              hop_ms_reg      <= 16'h0000;
              hop_state_reg   <= S_PUMP; // RL2
              pump_motor      <= 1'b1;
              stall_armed_reg <= 1'b1;
              stall_ms_reg    <= 16'h0000;
            end else begin
              hop_ms_reg <= hop_ms_reg + 16'h0001;
            end
          end
        end
        S_PUMP: begin
          if (ms_tick) begin
            if (hop_ms_reg == `THR_T_PUMP_MS - 16'd1) begin
              hop_ms_reg    <= 16'h0000;
              hop_state_reg <= S_SETTLE; // RL2
              pump_motor    <= 1'b0;
            end else begin
              hop_ms_reg <= hop_ms_reg + 16'h0001;
            end
          end
        end
        default: begin
          hop_state_reg <= S_SETTLE;
          hop_ms_reg    <= 16'h0000;
          pump_motor    <= 1'b0;
        end
      endcase
      // Low toner measured from pump start; one fault per refill attempt.
      if (!hop_low) begin
        stall_armed_reg <= 1'b0;
      end else if (stall_armed_reg && ms_tick && !(hop_state_reg == S_WAIT)) begin
        if (stall_ms_reg == `THR_T_STALL_MS) begin
          stall_evt       <= 1'b1; // RL3
          stall_armed_reg <= 1'b0;
        end else begin
          stall_ms_reg <= stall_ms_reg + 16'h0001;
        end
      end
    end
  end

  // Hopper agitator: with the pump, or for a slot earned by clutch time.
  always @(posedge clk) begin
    if (!rstn) begin
      agit_run_reg    <= 1'b0;
      agit_ms_reg     <= 16'h0000;
      clutch_ms_reg   <= 16'h0000;
      hopper_agitator <= 1'b0;
      pump_prev_reg   <= 1'b0;
      agit_prev_reg   <= 1'b0;
    end else begin
      pump_prev_reg   <= pump_motor;
      agit_prev_reg   <= hopper_agitator;
      hopper_agitator <= run && (pump_motor || agit_run_reg); // RL4
      if (!run) begin
        agit_run_reg <= 1'b0;
        agit_ms_reg  <= 16'h0000;
      end else if (agit_run_reg && ms_tick) begin
        if (agit_ms_reg == `THR_T_AGIT_MS - 16'd1) begin
          agit_run_reg <= 1'b0;
          agit_ms_reg  <= 16'h0000;
        end else begin
          agit_ms_reg <= agit_ms_reg + 16'h0001;
        end
      end else if (ms_tick && pin_reg[`THR_P_CLUTCH] &&
                   clutch_ms_reg == `THR_T_CLUTCH_MS - 16'd1) begin
        agit_run_reg <= 1'b1; // RL5
        agit_ms_reg  <= 16'h0000;
      end
      if (!hop_low || agit_rise) begin
        clutch_ms_reg <= 16'h0000; // RL6
      end else if (ms_tick && pin_reg[`THR_P_CLUTCH]) begin
        if (clutch_ms_reg == `THR_T_CLUTCH_MS - 16'd1)
          clutch_ms_reg <= 16'h0000;
        else
          clutch_ms_reg <= clutch_ms_reg + 16'h0001; // RL5
      end
    end
  end

  // Recycle shutter and purge by copy count.
  reg        copy_prev_reg;
  reg        recycling_reg;
  reg [31:0] copy_cnt_reg;
  reg        purge_evt;
  wire       copy_evt = pin_reg[`THR_P_COPY] && !copy_prev_reg;
  wire [31:0] copy_cnt_inc = copy_cnt_reg + 32'h0000_0001;

  always @(posedge clk) begin
    if (!rstn) begin
      copy_prev_reg    <= 1'b0;
      recycling_reg    <= 1'b1;
      copy_cnt_reg     <= 32'h0000_0000;
      shutter_solenoid <= 1'b0;
      purge_evt        <= 1'b0;
    end else begin
      copy_prev_reg    <= pin_reg[`THR_P_COPY];
      shutter_solenoid <= recycling_reg; // RL8
      purge_evt        <= 1'b0;
      if (copy_evt) begin
        if (recycling_reg && copy_cnt_inc > on_cnt_reg) begin
          recycling_reg <= 1'b0; // RL8
          copy_cnt_reg  <= 32'h0000_0000;
          purge_evt     <= 1'b1;
        end else if (!recycling_reg && copy_cnt_inc >= off_cnt_reg) begin
          recycling_reg <= 1'b1; // RL9
          copy_cnt_reg  <= 32'h0000_0000;
        end else begin
          copy_cnt_reg <= copy_cnt_inc;
        end
      end
    end
  end

  // Waste bottle supervision.
  wire agit_stuck;
  wire ovf_stuck;

  thr_rot_watch u_agit_watch (
    .clk       (clk),
    .rstn      (rstn),
    .ms_tick   (ms_tick),
    .drive_on  (pin_reg[`THR_P_BOT_AGIT]),
    .sense     (pin_reg[`THR_P_AGIT_ROT]),
    .window_ms (rot_win_reg),
    .stuck_reg (agit_stuck)
  );

  thr_rot_watch u_ovf_watch (
    .clk       (clk),
    .rstn      (rstn),
    .ms_tick   (ms_tick),
    .drive_on  (pin_reg[`THR_P_DRUM]),
    .sense     (pin_reg[`THR_P_OVF_ROT]),
    .window_ms (rot_win_reg),
    .stuck_reg (ovf_stuck)
  );

  // The full flag latches: once the coil stalls it stays full until reset,
  // since a coil that slips free does not mean the bottle emptied.
  always @(posedge clk) begin
    if (!rstn) begin
      bottle_near_full <= 1'b0;
      toner_full       <= 1'b0;
      bottle_not_set   <= 1'b0;
      machine_inhibit  <= 1'b0;
      feed_out_request <= 1'b0;
      stop_printing    <= 1'b0;
    end else begin
      bottle_near_full <= bottle_near_full || agit_stuck; // RL11
      toner_full       <= toner_full || ovf_stuck; // RL12
      bottle_not_set   <= !pin_reg[`THR_P_BOT_SET]; // RL13
      machine_inhibit  <= !cover_ok; // RL14
      feed_out_request <= toner_full && !path_empty; // RL12
      stop_printing    <= toner_full && path_empty; // RL12
    end
  end

  // Event capture: a new event beats a clear in the same cycle.
  wire [`THR_ST_W-1:0] st_set;
  assign st_set[`THR_ST_STALL]      = stall_evt;
  assign st_set[`THR_ST_NEAR_FULL]  = agit_stuck && !bottle_near_full;
  assign st_set[`THR_ST_FULL]       = ovf_stuck && !toner_full;
  assign st_set[`THR_ST_NOT_SET]    = !pin_reg[`THR_P_BOT_SET] && !bottle_not_set;
  assign st_set[`THR_ST_COVER_OPEN] = !cover_ok && !machine_inhibit;
  assign st_set[`THR_ST_PURGE]      = purge_evt;
  wire [`THR_ST_W-1:0] st_clr = (wr && addr == `THR_A_STATUS) ?
                                wdata[`THR_ST_W-1:0] : {`THR_ST_W{1'b0}};

  assign irq = |(status_reg & mask_reg);
  assign hopper_supply_stall_fault = status_reg[`THR_ST_STALL]; // RL3

  // On-time totals in milliseconds; a write to a total clears it.
  wire [4:0] on_src = {pump_motor, pin_reg[`THR_P_CYL_AGIT], pin_reg[`THR_P_BOT_AGIT],
                       pin_reg[`THR_P_CLUTCH], pin_reg[`THR_P_BANK]};
  integer i;
  always @(posedge clk) begin
    if (!rstn) begin
      for (i = 0; i < 5; i = i + 1)
        ontime_reg[i] <= 32'h0000_0000;
    end else begin
      for (i = 0; i < 5; i = i + 1) begin
        if (wr && addr == `THR_A_ONTIME0 + i[7:0] * 8'h04)
          ontime_reg[i] <= 32'h0000_0000;
        else if (ms_tick && on_src[i])
          ontime_reg[i] <= ontime_reg[i] + 32'h0000_0001; // RL7
      end
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      ctrl_en_reg <= `THR_RST_CTRL;
      status_reg  <= {`THR_ST_W{1'b0}};
      mask_reg    <= {`THR_ST_W{1'b0}};
      on_cnt_reg  <= `THR_RST_ON_CNT;
      off_cnt_reg <= `THR_RST_OFF_CNT;
      rot_win_reg <= `THR_RST_ROT_WIN;
    end else begin
      status_reg <= (status_reg & ~st_clr) | st_set;
      if (wr) begin
        case (addr)
          `THR_A_CTRL:    ctrl_en_reg <= wdata[0];
          `THR_A_MASK:    mask_reg    <= wdata[`THR_ST_W-1:0];
          `THR_A_ON_CNT:  on_cnt_reg  <= wdata; // RL10
          `THR_A_OFF_CNT: off_cnt_reg <= wdata; // RL10
          `THR_A_ROT_WIN: rot_win_reg <= wdata[15:0]; // RL15
          default: ;
        endcase
      end
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        `THR_A_CTRL:     rdata <= {31'h0, ctrl_en_reg};
        `THR_A_STATUS:   rdata <= {26'h0, status_reg};
        `THR_A_MASK:     rdata <= {26'h0, mask_reg};
        `THR_A_ON_CNT:   rdata <= on_cnt_reg;
        `THR_A_OFF_CNT:  rdata <= off_cnt_reg;
        `THR_A_ROT_WIN:  rdata <= {16'h0, rot_win_reg};
        `THR_A_LIVE:     rdata <= {22'h0, recycling_reg, agit_run_reg, hopper_agitator,
                                   pump_motor, run, hop_low, hop_state_reg};
        `THR_A_COPY_CNT: rdata <= copy_cnt_reg;
        8'h20:           rdata <= ontime_reg[0]; // RL7
        8'h24:           rdata <= ontime_reg[1];
        8'h28:           rdata <= ontime_reg[2];
        8'h2c:           rdata <= ontime_reg[3];
        `THR_A_ONTIME4:  rdata <= ontime_reg[4];
        default:         rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

endmodule // thr_hopper_ctrl

`default_nettype wire

/* File: sim/thr_hopper_ctrl_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module thr_hopper_ctrl_chk #(
  parameter int MS_CYCLES = 4
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic [11:0] pins,
  input wire logic        pump_motor,
  input wire logic        hopper_agitator,
  input wire logic        shutter_solenoid,
  input wire logic        machine_inhibit,
  input wire logic        bottle_near_full,
  input wire logic        toner_full,
  input wire logic        bottle_not_set,
  input wire logic        feed_out_request,
  input wire logic        stop_printing,
  input wire logic        hopper_supply_stall_fault
);
  localparam int T2S = 2000 * MS_CYCLES;
  logic [31:0] pump_len;
  logic [31:0] since_fall;
  logic [31:0] since_pump;
  logic        agit_q, pump_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Cover-open time restarts the settle phase, so it restarts the count too.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pump_len   <= '0;
      since_fall <= '0;
      since_pump <= '0;
      agit_q     <= 1'b0;
      pump_q     <= 1'b0;
    end else begin
      agit_q     <= hopper_agitator;
      pump_q     <= pump_motor;
      pump_len   <= pump_motor ? pump_len + 1 : '0;
      since_fall <= (machine_inhibit || (agit_q && !hopper_agitator)) ? '0 : since_fall + 1;
      since_pump <= (pump_motor && !pump_q) ? '0 : since_pump + 1;
    end
  end
  property p_agit_pump;
    pump_motor |=> hopper_agitator || !pump_motor;
  endproperty
  property p_pump_len;
    $fell(pump_motor) && !machine_inhibit |-> pump_len >= T2S - MS_CYCLES
      && pump_len <= T2S + MS_CYCLES;
  endproperty
  property p_sample_wait;
    $rose(pump_motor) |-> since_fall >= T2S - 3 * MS_CYCLES && since_fall <= T2S + 3 * MS_CYCLES;
  endproperty
  property p_stall;
    $rose(hopper_supply_stall_fault) |-> since_pump >= T2S && since_pump <= T2S + 4 * MS_CYCLES;
  endproperty
  property p_inhibit;
    (!pins[9]) [*5] |-> machine_inhibit;
  endproperty
  property p_run;
    pins[9] [*5] |-> !machine_inhibit;
  endproperty
  property p_no_pump;
    machine_inhibit [*2] |-> !pump_motor;
  endproperty
  property p_not_set;
    (!pins[8]) [*5] |-> bottle_not_set;
  endproperty
  property p_full_out;
    feed_out_request || stop_printing |-> toner_full && !(feed_out_request && stop_printing);
  endproperty
  property p_near_latch;
    bottle_near_full |=> bottle_near_full;
  endproperty
  property p_rd_idle;
    !$past(rd) |-> rdata == 32'h0;
  endproperty
  a_agit_pump: assert property (p_agit_pump) else $error("agitator lags pump");
  a_pump_len: assert property (p_pump_len) else $error("pump run length wrong");
  a_sample_wait: assert property (p_sample_wait) else $error("pump start mistimed");
  a_stall: assert property (p_stall) else $error("stall fault mistimed");
  a_inhibit: assert property (p_inhibit) else $error("cover open not inhibiting");
  a_run: assert property (p_run) else $error("inhibit with cover closed");
  a_no_pump: assert property (p_no_pump) else $error("pump runs while inhibited");
  a_not_set: assert property (p_not_set) else $error("bottle not set missing");
  a_full_out: assert property (p_full_out) else $error("feed out or stop wrong");
  a_near_latch: assert property (p_near_latch) else $error("near full dropped");
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  c_pump: cover property ($rose(pump_motor));
  c_stall: cover property ($rose(hopper_supply_stall_fault));
  c_purge: cover property ($fell(shutter_solenoid));
  c_stop: cover property ($rose(stop_printing));
endmodule // thr_hopper_ctrl_chk

bind thr_hopper_ctrl thr_hopper_ctrl_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .clk(clk), .rstn(rstn), .rd(rd), .rdata(rdata), .pins(pins), .pump_motor(pump_motor),
  .hopper_agitator(hopper_agitator), .shutter_solenoid(shutter_solenoid),
  .machine_inhibit(machine_inhibit), .bottle_near_full(bottle_near_full),
  .toner_full(toner_full), .bottle_not_set(bottle_not_set),
  .feed_out_request(feed_out_request), .stop_printing(stop_printing),
  .hopper_supply_stall_fault(hopper_supply_stall_fault));
`default_nettype wire

/* File: sim/thr_plant_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Hopper refills after 100 ms of pumping unless refill is blocked; the rotation
// sensors toggle each millisecond while their drive runs and hold still when jammed.
module thr_plant_model #(
  parameter int MS_CYCLES = 4
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic pump_motor,
  input  wire logic agit_drive,
  input  wire logic drum_drive,
  input  wire logic fill_ok,
  input  wire logic drain,
  input  wire logic jam_agit,
  input  wire logic jam_ovf,
  output var  logic hop_low,
  output var  logic agit_rot,
  output var  logic ovf_rot
);
  int ms_cnt;
  int pump_ms;
  always @(posedge clk) begin
    if (!rstn) begin
      ms_cnt   <= 0;
      pump_ms  <= 0;
      hop_low  <= 1'b1;
      agit_rot <= 1'b0;
      ovf_rot  <= 1'b0;
    end else begin
      ms_cnt <= (ms_cnt == MS_CYCLES - 1) ? 0 : ms_cnt + 1;
      if (ms_cnt == 0) begin
        pump_ms <= pump_motor ? pump_ms + 1 : 0;
        if (agit_drive && !jam_agit) agit_rot <= !agit_rot;
        if (drum_drive && !jam_ovf) ovf_rot <= !ovf_rot;
      end
      if (drain) hop_low <= 1'b1;
      else if (fill_ok && pump_ms >= 100) hop_low <= 1'b0;
    end
  end
endmodule // thr_plant_model
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int MS = 4;
  logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, d;
  logic [11:0] pin_drv = 12'h300;
  logic        fill_ok = 1'b1, drain = 1'b0, jam_agit = 1'b0, jam_ovf = 1'b0;
  wire logic [31:0] rdata;
  wire logic [11:0] pins;
  wire logic   irq, pump_motor, hopper_agitator, shutter_solenoid, machine_inhibit;
  wire logic   bottle_near_full, toner_full, bottle_not_set, feed_out_request, stop_printing;
  wire logic   hopper_supply_stall_fault, hop_low, agit_rot, ovf_rot;
  int          error_cnt = 0, samples_checked = 0, cyc = 0, t_rel, n;
  assign pins = {pin_drv[11:8], ovf_rot, agit_rot, pin_drv[5:1], hop_low};
  thr_hopper_ctrl #(.MS_CYCLES(MS)) dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .pins(pins), .pump_motor(pump_motor),
    .hopper_agitator(hopper_agitator), .shutter_solenoid(shutter_solenoid),
    .machine_inhibit(machine_inhibit), .bottle_near_full(bottle_near_full),
    .toner_full(toner_full), .bottle_not_set(bottle_not_set),
    .feed_out_request(feed_out_request), .stop_printing(stop_printing),
    .hopper_supply_stall_fault(hopper_supply_stall_fault));
  thr_plant_model #(.MS_CYCLES(MS)) u_plant (.clk(clk), .rstn(rstn), .pump_motor(pump_motor),
    .agit_drive(pin_drv[3]), .drum_drive(pin_drv[5]), .fill_ok(fill_ok), .drain(drain),
    .jam_agit(jam_agit), .jam_ovf(jam_ovf), .hop_low(hop_low), .agit_rot(agit_rot),
    .ovf_rot(ovf_rot));
  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
    samples_checked++;
    if ($isunknown(got) || got < lo || got > hi) begin
      error_cnt++;
      $display("[FAIL] %0t value %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk) {wr, addr, wdata} <= {1'b1, a, v};
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk) {rd, addr} <= {1'b1, a};
    @(posedge clk) rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic ms_wait(input int m);
    repeat (m * MS) @(posedge clk);
    #1;
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return pump_motor;
      1: return hopper_agitator;
      2: return hopper_supply_stall_fault;
      3: return bottle_near_full;
      default: return toner_full;
    endcase
  endfunction
  // A wait that is expected to run out passes must = 0 and checks the signal itself.
  task automatic wait_for(input int s, input logic v, input int lim, input bit must);
    n = 0;
    while (sig(s) !== v && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
    if (must && n == lim) begin
      error_cnt++;
      $display("[FAIL] %0t wait ran out", $time);
      test_done();
    end
  endtask
  task automatic copy();
    @(posedge clk) pin_drv[10] <= 1'b1;
    repeat (4) @(posedge clk);
    pin_drv[10] <= 1'b0;
    ms_wait(2);
  endtask
  task automatic t_regs();
    rd_reg(8'h00); chk(d, 32'h1);
    rd_reg(8'h08); chk(d, 32'h0);
    rd_reg(8'h0c); chk(d, 32'd25000);
    rd_reg(8'h10); chk(d, 32'd25000);
    rd_reg(8'h14); chk(d, 32'd3000);
    rd_reg(8'h44); chk(d, 32'h0);
    wr_reg(8'h0c, 32'h3); wr_reg(8'h10, 32'h2); wr_reg(8'h14, 32'h5); wr_reg(8'h1c, 32'h7);
    rd_reg(8'h0c); chk(d, 32'h3);
    rd_reg(8'h10); chk(d, 32'h2);
    rd_reg(8'h1c); chk(d, 32'h0);
  endtask
  task automatic t_recycle();
    chk(shutter_solenoid, 1'b1);
    for (int i = 1; i <= 6; i++) begin
      copy();
      chk(shutter_solenoid, (i == 4 || i == 5) ? 1'b0 : 1'b1);
    end
    rd_reg(8'h04); chk(d, 32'h20);
  endtask
  task automatic t_first_pump();
    wait_for(0, 1'b1, 2100 * MS, 1'b1);
    chk_rng(cyc - t_rel, 1997 * MS, 2003 * MS);
    @(posedge clk) #1 chk(hopper_agitator, 1'b1);
    wait_for(0, 1'b0, 2100 * MS, 1'b1);
    chk_rng(n, 1999 * MS, 2001 * MS);
    chk(hop_low, 1'b0);
    chk(hopper_supply_stall_fault, 1'b0);
  endtask
  task automatic t_clutch();
    ms_wait(1100);
    @(posedge clk) {pin_drv[1], fill_ok} <= 2'b10;
    wait_for(1, 1'b1, 700 * MS, 1'b0);
    chk(hopper_agitator, 1'b0);
    @(posedge clk) drain <= 1'b1;
    wait_for(1, 1'b1, 600 * MS, 1'b1);
    chk_rng(n, 497 * MS, 504 * MS);
    @(posedge clk) pin_drv[1] <= 1'b0;
    wait_for(1, 1'b0, 600 * MS, 1'b1);
    chk_rng(n, 498 * MS, 501 * MS);
  endtask
  task automatic t_stall();
    wait_for(2, 1'b1, 4300 * MS, 1'b1);
    chk(irq, 1'b0);
    wr_reg(8'h08, 32'h1);
    #1 chk(irq, 1'b1);
    rd_reg(8'h04); chk(d & 32'h1, 32'h1);
    wr_reg(8'h04, 32'h1);
    #1 chk(irq, 1'b0);
    chk(hopper_supply_stall_fault, 1'b0);
    rd_reg(8'h30); chk_rng(d, 3998, 4002);
    rd_reg(8'h24); chk_rng(d, 1180, 1230);
    wr_reg(8'h30, 32'h0);
    rd_reg(8'h30); chk(d, 32'h0);
    @(posedge clk) {drain, fill_ok} <= 2'b01;
  endtask
  task automatic t_bottle();
    @(posedge clk) pin_drv[3] <= 1'b1;
    ms_wait(20);
    chk(bottle_near_full, 1'b0);
    @(posedge clk) jam_agit <= 1'b1;
    wait_for(3, 1'b1, 12 * MS, 1'b1);
    chk_rng(n, 3 * MS, 9 * MS);
    @(posedge clk) {pin_drv[5], jam_ovf} <= 2'b11;
    wait_for(4, 1'b1, 12 * MS, 1'b1);
    ms_wait(1);
    chk({feed_out_request, stop_printing}, 2'b10);
    @(posedge clk) pin_drv[11] <= 1'b1;
    ms_wait(2);
    chk({feed_out_request, stop_printing}, 2'b01);
    @(posedge clk) pin_drv[8] <= 1'b0;
    ms_wait(2);
    chk(bottle_not_set, 1'b1);
    @(posedge clk) pin_drv[9:8] <= 2'b01;
    ms_wait(2);
    chk({machine_inhibit, pump_motor}, 2'b10);
    @(posedge clk) pin_drv[9] <= 1'b1;
    ms_wait(2);
    chk({machine_inhibit, bottle_not_set}, 2'b00);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_rel = cyc;
    t_regs();
    t_recycle();
    t_first_pump();
    t_clutch();
    t_stall();
    t_bottle();
    test_done();
  end
endmodule // testbench
`default_nettype wire
